// [common/tcc_pkg.sv]
// constants and types shared by the timer capture/compare channel
package tcc_pkg;
    localparam int CountWidth = 16;
    localparam logic [15:0] CountReset = 16'h0000;
    localparam logic [15:0] CompareReset = 16'h0000;
    localparam logic [15:0] CountMax = 16'hFFFF;
    localparam logic [15:0] CountOne = 16'h0001;
    localparam logic [2:0] SyncReset = 3'h0;

    // counter operating modes
    typedef enum logic [2:0]
    {
        MODE_STOP = 3'b001,
        MODE_FREE = 3'b010,
        MODE_CLEAR_MATCH = 3'b100
    } mode_t;
endpackage

// [rtl/timer_capture_compare_channel.sv]
// capture/compare channel 0 of a 16-bit timer/event counter
//----------------------------------------------------------------
//----------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module timer_capture_compare_channel
    import tcc_pkg::*;
#(
    parameter int Width = CountWidth
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic countTick,
    input wire logic runEnable,
    input wire logic clearOnMatch,
    input wire logic clearOnEdge,
    input wire logic captureMode,
    input wire logic outputSelect,
    input wire logic compareWrite,
    input wire logic [15:0] compareData,
    input wire logic countRead,
    input wire logic compareRead,
    input wire logic edge_trigger_input_a,
    input wire logic shared_port_pin_in,
    output logic shared_port_pin_out,
    output logic shared_port_pin_oe,
    output logic [15:0] readData,
    output logic channel0_match_irq,
    output logic running
);
    logic [2:0] syncA_r, syncA_nxt, syncB_r, syncB_nxt;
    logic [15:0] timer_count_value_r, count_nxt;
    logic [15:0] capture_compare_value_0_r, ccv_nxt;
    logic [15:0] readData_r, readData_nxt;
    logic irq_r, irq_nxt, out_r, out_nxt, oe_r, oe_nxt;
    logic heldTick_r, heldTick_nxt;
    mode_t mode_r, mode_nxt;
    logic edgeA, edgeB, tick, match, capTrig;
    logic levelA_r, levelA_nxt, levelB_r, levelB_nxt, running_r, running_nxt;
    logic agreeA, agreeB;

    //----------------------------------------------------------------
    // input synchronisers and edge detection
    //----------------------------------------------------------------
    // three stages: a change counts once stages two and three agree
    assign agreeA = (syncA_r[1] == syncA_r[2]);
    assign agreeB = (syncB_r[1] == syncB_r[2]);
    always_comb
    begin
        syncA_nxt = {syncA_r[1:0], edge_trigger_input_a};
        syncB_nxt = {syncB_r[1:0], shared_port_pin_in};
        levelA_nxt = agreeA ? syncA_r[2] : levelA_r;
        levelB_nxt = agreeB ? syncB_r[2] : levelB_r;
    end
    // rising edge: agreed level is high while the accepted level is still low
    assign edgeA = agreeA & syncA_r[2] & ~levelA_r;
    assign edgeB = agreeB & syncB_r[2] & ~levelB_r & ~outputSelect;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            syncA_r <= SyncReset;
            syncB_r <= SyncReset;
            levelA_r <= 1'b0;
            levelB_r <= 1'b0;
        end
        else
        begin
            syncA_r <= syncA_nxt;
            syncB_r <= syncB_nxt;
            levelA_r <= levelA_nxt;
            levelB_r <= levelB_nxt;
        end
    end

    //----------------------------------------------------------------
    // counter, compare and capture
    //----------------------------------------------------------------
    // a tick arriving during a count read is held; it stays pending while ticks keep coming
    assign tick = (countTick | heldTick_r) & ~countRead;
    assign match = (timer_count_value_r == capture_compare_value_0_r);
    assign capTrig = captureMode & edgeA;
    always_comb
    begin
        mode_nxt = !runEnable ? MODE_STOP : (clearOnMatch ? MODE_CLEAR_MATCH : MODE_FREE);
        running_nxt = (mode_nxt != MODE_STOP);
        count_nxt = timer_count_value_r;
        ccv_nxt = capture_compare_value_0_r;
        irq_nxt = 1'b0;
        out_nxt = out_r;
        oe_nxt = outputSelect;
        heldTick_nxt = countRead ? (countTick | heldTick_r) : (countTick & heldTick_r);
        readData_nxt = readData_r;
        if (mode_r == MODE_STOP)
        begin
            count_nxt = CountReset;
        end
        else if (tick)
        begin
            if (mode_r == MODE_CLEAR_MATCH && match && capture_compare_value_0_r != CountReset)
            begin
                count_nxt = CountReset;
                irq_nxt = 1'b1;
                out_nxt = ~out_r;
            end
            else
            begin
                count_nxt = timer_count_value_r + CountOne;
                // compare zero matches only on the step from zero to one
                if (match)
                begin
                    irq_nxt = 1'b1;
                    out_nxt = ~out_r;
                end
            end
        end
        if (mode_r != MODE_STOP && clearOnEdge && !captureMode && (edgeA | edgeB))
        begin
            count_nxt = CountReset;
        end
        if (!captureMode && compareWrite)
        begin
            ccv_nxt = compareData;
        end
        // capture load beats a concurrent read; no capture while stopped, the register keeps its value
        if (capTrig && mode_r != MODE_STOP)
        begin
            ccv_nxt = timer_count_value_r;
        end
        if (countRead)
        begin
            readData_nxt = timer_count_value_r;
        end
        else if (compareRead)
        begin
            readData_nxt = capture_compare_value_0_r;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            mode_r <= MODE_STOP;
            timer_count_value_r <= CountReset;
            capture_compare_value_0_r <= CompareReset;
            irq_r <= 1'b0;
            out_r <= 1'b0;
            oe_r <= 1'b0;
            heldTick_r <= 1'b0;
            readData_r <= CountReset;
            running_r <= 1'b0;
        end
        else
        begin
            mode_r <= mode_nxt;
            timer_count_value_r <= count_nxt;
            capture_compare_value_0_r <= ccv_nxt;
            irq_r <= irq_nxt;
            out_r <= out_nxt;
            oe_r <= oe_nxt;
            heldTick_r <= heldTick_nxt;
            readData_r <= readData_nxt;
            running_r <= running_nxt;
        end
    end

    assign shared_port_pin_out = out_r;
    assign shared_port_pin_oe = oe_r;
    assign readData = readData_r;
    assign channel0_match_irq = irq_r;
    assign running = running_r;

    //----------------------------------------------------------------
    // assertions
    //----------------------------------------------------------------
    property p_wrap;
        @(posedge clk) disable iff (!rstn)
        (mode_r == MODE_FREE && tick && timer_count_value_r == CountMax && !clearOnEdge && runEnable)
        |=> timer_count_value_r == CountReset;
    endproperty
    a_wrap: assert property (p_wrap) else $error("counter did not wrap");

    property p_zero_irq;
        @(posedge clk) disable iff (!rstn)
        (mode_r == MODE_FREE && tick && capture_compare_value_0_r == CountReset
         && timer_count_value_r == CountReset) |=> channel0_match_irq;
    endproperty
    a_zero_irq: assert property (p_zero_irq) else $error("zero compare missed irq");

    property p_clear;
        @(posedge clk) disable iff (!rstn)
        (mode_r == MODE_CLEAR_MATCH && tick && match && capture_compare_value_0_r != CountReset && runEnable)
        |=> timer_count_value_r == CountReset && channel0_match_irq;
    endproperty
    a_clear: assert property (p_clear) else $error("match did not clear");

    property p_no_clear_below;
        @(posedge clk) disable iff (!rstn)
        (mode_r != MODE_STOP && tick && !match && !clearOnEdge && runEnable && timer_count_value_r != CountMax)
        |=> timer_count_value_r == $past(timer_count_value_r) + CountOne;
    endproperty
    a_no_clear_below: assert property (p_no_clear_below) else $error("counter cleared off match");

    property p_read_hold;
        @(posedge clk) disable iff (!rstn)
        (countRead && mode_r != MODE_STOP && !clearOnEdge) |=> timer_count_value_r == $past(timer_count_value_r);
    endproperty
    a_read_hold: assert property (p_read_hold) else $error("count moved during read");

    property p_tick_kept;
        @(posedge clk) disable iff (!rstn)
        (countRead && countTick) |=> heldTick_r;
    endproperty
    a_tick_kept: assert property (p_tick_kept) else $error("tick lost during read");

    property p_capture_wins;
        @(posedge clk) disable iff (!rstn)
        (capTrig && compareRead && mode_r != MODE_STOP)
        |=> capture_compare_value_0_r == $past(timer_count_value_r);
    endproperty
    a_capture_wins: assert property (p_capture_wins) else $error("capture lost to read");

    property p_no_capture_compare;
        @(posedge clk) disable iff (!rstn)
        (!captureMode && !compareWrite) |=> $stable(capture_compare_value_0_r);
    endproperty
    a_no_capture_compare: assert property (p_no_capture_compare) else $error("compare reg changed");

    property p_pin_oe;
        @(posedge clk) disable iff (!rstn)
        outputSelect |=> shared_port_pin_oe;
    endproperty
    a_pin_oe: assert property (p_pin_oe) else $error("pin not driven");
endmodule
`default_nettype wire

// [testbench/edge_source.sv]
// partner model: external edge source for input a; input b is kept quiet
`timescale 1ns/1ps
`default_nettype none
module edge_source
(
    input wire logic clk,
    input wire logic fire,
    input wire logic pinDriven,
    output logic pinA,
    output logic pinB
);
    logic [2:0] hold_r = 3'h0;
    // one rising edge on input a, held long enough for the synchroniser
    always @(posedge clk)
    begin
        if (fire)
            hold_r <= 3'h4;
        else if (hold_r != 3'h0)
            hold_r <= hold_r - 3'h1;
    end
    assign pinA = (hold_r != 3'h0);
    // input b stays quiet and lets go while the pin is an output
    assign pinB = pinDriven ? 1'bz : 1'b0;
endmodule
`default_nettype wire

// [testbench/tb_timer_capture_compare_channel.sv]
// self-checking bench for the timer capture/compare channel
`timescale 1ns/1ps
`default_nettype none
module tb_timer_capture_compare_channel import tcc_pkg::*;;
    logic clk = 0, rstn = 0, countTick = 0, runEnable = 0, clearOnMatch = 0, captureMode = 0;
    logic outputSelect = 0, compareWrite = 0, countRead = 0, compareRead = 0, fire = 0, clearOnEdge = 0;
    logic [15:0] compareData = 16'h0000;
    wire logic pinA, pinB, pinOut, pinOe, irq, running, pinLevel;
    wire logic [15:0] readData;
    int errCount = 0, samplesChecked = 0, irqCount = 0, base;
    typedef struct {int ticks; logic [15:0] exp;} row_t;
    row_t rows[4] = '{'{0, 16'h0000}, '{1, 16'h0001}, '{7, 16'h0007}, '{300, 16'h012C}};
    // ---------------------------------------------
    // design, partner and wire level of the shared pin
    // ---------------------------------------------
    timer_capture_compare_channel DUT (.clk(clk), .rstn(rstn), .countTick(countTick),
        .runEnable(runEnable), .clearOnMatch(clearOnMatch), .clearOnEdge(clearOnEdge),
        .captureMode(captureMode), .outputSelect(outputSelect), .compareWrite(compareWrite),
        .compareData(compareData), .countRead(countRead), .compareRead(compareRead),
        .edge_trigger_input_a(pinA), .shared_port_pin_in(pinLevel), .shared_port_pin_out(pinOut),
        .shared_port_pin_oe(pinOe), .readData(readData), .channel0_match_irq(irq), .running(running));
    edge_source partner (.clk(clk), .fire(fire), .pinDriven(pinOe), .pinA(pinA), .pinB(pinB));
    assign pinLevel = pinOe ? pinOut : pinB;
    // clock, match pulse counter and watchdog
    initial forever #25 clk = ~clk;
    always @(posedge clk) if (irq === 1'b1) irqCount <= irqCount + 1;
    initial
    begin
        repeat (90000) @(posedge clk);
        errCount++;
        end_sim();
    end
    // ---------------------------------------------
    // shared tasks
    // ---------------------------------------------
    task check(input logic [15:0] seen, input logic [15:0] exp);
        samplesChecked++;
        if (seen !== exp)
        begin
            errCount++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task tick(input int n);
        for (int i = 0; i < n; i++) @(posedge clk) countTick <= 1'b1;
        @(posedge clk) countTick <= 1'b0;
    endtask
    task rd(input logic sel, input logic doCheck, input logic [15:0] exp);
        @(posedge clk) if (sel) compareRead <= 1'b1; else countRead <= 1'b1;
        @(posedge clk) begin compareRead <= 1'b0; countRead <= 1'b0; end
        cyc(2);
        #1;
        if (doCheck) check(readData, exp);
    endtask
    task restart();
        @(posedge clk) runEnable <= 1'b0;
        cyc(2);
        runEnable <= 1'b1;
        cyc(3);
    endtask
    task writeCmp(input logic [15:0] v);
        @(posedge clk) begin compareWrite <= 1'b1; compareData <= v; end
        @(posedge clk) compareWrite <= 1'b0;
    endtask
    task end_sim();
        $display("errors %0d checks %0d", errCount, samplesChecked);
        if (errCount == 0 && samplesChecked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // ---------------------------------------------
    // main sequence
    // ---------------------------------------------
    initial
    begin
        cyc(20);
        rstn <= 1'b1;
        #1 check({12'h000, irq, pinOe, pinOut, running}, 16'h0000);
        check(readData, 16'h0000);
        foreach (rows[i])
        begin
            restart();
            tick(rows[i].ticks);
            rd(1'b0, 1'b1, rows[i].exp);
        end
        // a tick that meets a counter read is not lost
        restart();
        tick(5);
        @(posedge clk) begin countTick <= 1'b1; countRead <= 1'b1; end
        @(posedge clk) countRead <= 1'b0;
        @(posedge clk) countTick <= 1'b0;
        #1 check(readData, 16'h0005);
        cyc(3);
        rd(1'b0, 1'b1, 16'h0007);
        // clear on match with a nonzero compare value
        @(posedge clk) clearOnMatch <= 1'b1;
        writeCmp(16'h0003);
        restart();
        base = irqCount;
        tick(8);
        cyc(4);
        check(16'(irqCount - base), 16'h0002);
        rd(1'b0, 1'b1, 16'h0000);
        // compare lowered below the count: no clear, counting goes on
        writeCmp(16'h0008);
        restart();
        tick(5);
        base = irqCount;
        writeCmp(16'h0002);
        tick(3);
        rd(1'b0, 1'b1, 16'h0008);
        check(16'(irqCount - base), 16'h0000);
        restart();
        tick(3);
        rd(1'b0, 1'b1, 16'h0000);
        // free running with compare zero: event only on 0 to 1 after a wrap
        @(posedge clk) clearOnMatch <= 1'b0;
        writeCmp(16'h0000);
        restart();
        tick(2);
        cyc(3);
        base = irqCount;
        tick(65534);
        cyc(3);
        check(16'(irqCount - base), 16'h0000);
        rd(1'b0, 1'b1, 16'h0000);
        tick(1);
        cyc(3);
        check(16'(irqCount - base), 16'h0001);
        // capture, then capture colliding with a register read
        @(posedge clk) captureMode <= 1'b1;
        restart();
        tick(4);
        @(posedge clk) fire <= 1'b1;
        @(posedge clk) fire <= 1'b0;
        cyc(8);
        rd(1'b1, 1'b1, 16'h0004);
        tick(5);
        @(posedge clk) fire <= 1'b1;
        @(posedge clk) fire <= 1'b0;
        cyc(2);
        rd(1'b1, 1'b0, 16'h0000);
        cyc(6);
        rd(1'b1, 1'b1, 16'h0009);
        // edge clear in compare configuration restarts the count from zero
        @(posedge clk) begin captureMode <= 1'b0; clearOnEdge <= 1'b1; end
        restart();
        tick(6);
        @(posedge clk) fire <= 1'b1;
        @(posedge clk) fire <= 1'b0;
        cyc(8);
        rd(1'b0, 1'b1, 16'h0000);
        tick(2);
        rd(1'b0, 1'b1, 16'h0002);
        // shared pin serves one function at a time
        @(posedge clk) begin clearOnEdge <= 1'b0; outputSelect <= 1'b1; end
        cyc(3);
        #1 check({15'h0000, pinOe}, 16'h0001);
        check({14'h0000, running, pinOut}, {14'h0000, 1'b1, irqCount[0]});
        @(posedge clk) outputSelect <= 1'b0;
        cyc(3);
        #1 check({15'h0000, pinOe}, 16'h0000);
        end_sim();
    end
endmodule
`default_nettype wire
